//--- dtc_pkg.sv
// Constants and types shared by the dual timer/counter block
package dtc_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0]  CTRL_IDX     = 8'h88;
  localparam logic [7:0]  MODE_IDX     = 8'h89;
  localparam logic [7:0]  TL0_IDX      = 8'h8a;
  localparam logic [7:0]  TL1_IDX      = 8'h8b;
  localparam logic [7:0]  TH0_IDX      = 8'h8c;
  localparam logic [7:0]  TH1_IDX      = 8'h8d;
  localparam logic [7:0]  BSET_IDX     = 8'h90;
  localparam logic [7:0]  BCLR_IDX     = 8'h91;
  localparam logic [7:0]  ISTAT_IDX    = 8'h92;
  localparam logic [7:0]  IMASK_IDX    = 8'h93;
  localparam int          ADDR_W       = 12;

  // Decoded register selector
  localparam logic [3:0]  SEL_CTRL     = 4'h0;
  localparam logic [3:0]  SEL_MODE     = 4'h1;
  localparam logic [3:0]  SEL_TL0      = 4'h2;
  localparam logic [3:0]  SEL_TL1      = 4'h3;
  localparam logic [3:0]  SEL_TH0      = 4'h4;
  localparam logic [3:0]  SEL_TH1      = 4'h5;
  localparam logic [3:0]  SEL_BSET     = 4'h6;
  localparam logic [3:0]  SEL_BCLR     = 4'h7;
  localparam logic [3:0]  SEL_ISTAT    = 4'h8;
  localparam logic [3:0]  SEL_IMASK    = 4'h9;
  localparam logic [3:0]  SEL_NONE     = 4'hf;

  // Control register bit positions
  localparam int          T1_OVF_BIT   = 7;
  localparam int          T1_RUN_BIT   = 6;
  localparam int          T0_OVF_BIT   = 5;
  localparam int          T0_RUN_BIT   = 4;
  localparam int          X1_REQ_BIT   = 3;
  localparam int          X1_TYPE_BIT  = 2;
  localparam int          X0_REQ_BIT   = 1;
  localparam int          X0_TYPE_BIT  = 0;

  // Mode register bit positions
  localparam int          T1_GATE_BIT  = 7;
  localparam int          T1_SRC_BIT   = 6;
  localparam int          T1_MODE_HI   = 5;
  localparam int          T1_MODE_LO   = 4;
  localparam int          T0_GATE_BIT  = 3;
  localparam int          T0_SRC_BIT   = 2;
  localparam int          T0_MODE_HI   = 1;
  localparam int          T0_MODE_LO   = 0;

  // Reset values
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [7:0]  MODE_RST     = 8'h00;
  localparam logic [7:0]  CNT_RST      = 8'h00;
  localparam logic [3:0]  IRQ_RST      = 4'h0;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  typedef enum logic [1:0] {
    MODE_PRESCALE = 2'b00,
    MODE_FULL     = 2'b01,
    MODE_RELOAD   = 2'b10,
    MODE_SPLIT    = 2'b11
  } dtc_mode_t;
endpackage : dtc_pkg

//--- dtc_top.sv
// Dual 16-bit timer/counter with external request flags and AXI4-Lite slave
// Map: byte address is four times the index
//   0x220 control, 0x224 mode
//   0x228, 0x22c low bytes, timers 0, 1
//   0x230, 0x234 high bytes, timers 0, 1
//   0x240 set bits, 0x244 clear bits
//   0x248 status, write one to clear
//   0x24c mask, same layout
//
// Timing
//   Pin fall seen three cycles later
//   Write answered two cycles on
//   Read answered one cycle on
//   irq rises with status, same edge
//   Count or write: write wins
//
// Reset
//   Readies rise one cycle after release
//   Sync flops reset to one
//
// Interrupts
//   Controller acks clear overflow and edge request flags
//   Status and mask drive irq
//   Event wins over a clear
//
// Limitations
//   Only byte lane 0 is used
//   Strobe 0 low: write ignored, OKAY
//   Unmapped: SLVERR, no effect
//   Split mode takes timer one's flag
//   One write and one read at a time
//
// Chosen here: register access over AXI4-Lite.
module dtc_top
  import dtc_pkg::*;
(
  input  wire logic              clk,           // Core clock, 10 MHz
  input  wire logic              rstn,          // Asynchronous reset, active low
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // Write address
  input  wire logic              s_axi_awvalid, // Write address valid
  output logic                   s_axi_awready, // Write address ready
  input  wire logic [31:0]       s_axi_wdata,   // Write data
  input  wire logic [3:0]        s_axi_wstrb,   // Write byte strobes
  input  wire logic              s_axi_wvalid,  // Write data valid
  output logic                   s_axi_wready,  // Write data ready
  output logic [1:0]             s_axi_bresp,   // Write response
  output logic                   s_axi_bvalid,  // Write response valid
  input  wire logic              s_axi_bready,  // Write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,  // Read address
  input  wire logic              s_axi_arvalid, // Read address valid
  output logic                   s_axi_arready, // Read address ready
  output logic [31:0]            s_axi_rdata,   // Read data
  output logic [1:0]             s_axi_rresp,   // Read response
  output logic                   s_axi_rvalid,  // Read data valid
  input  wire logic              s_axi_rready,  // Read data ready
  input  wire logic              countInZeroPin, // Timer zero count input
  input  wire logic              countInOnePin,  // Timer one count input
  input  wire logic              extintZeroPin,  // External request zero, low active
  input  wire logic              extintOnePin,   // External request one, low active
  input  wire logic              ackTimerZero,   // Service of timer zero begins
  input  wire logic              ackTimerOne,    // Service of timer one begins
  input  wire logic              ackExtintZero,  // Service of request zero begins
  input  wire logic              ackExtintOne,   // Service of request one begins
  output logic                   timerZeroOverflowFlag, // Flag to interrupt controller
  output logic                   timerOneOverflowFlag,  // Flag to interrupt controller
  output logic                   extintZeroRequestFlag, // Flag to interrupt controller
  output logic                   extintOneRequestFlag,  // Flag to interrupt controller
  output logic                   irq            // Level interrupt, unmasked status
);

  // Address decode shared by read and write paths
  // Misaligned or far addresses: none
  function automatic logic [3:0] decodeSel(input logic [ADDR_W-1:0] a);
    logic [3:0] s;
    s = SEL_NONE;
    if (a[1:0] == 2'b00 && a[ADDR_W-1:10] == '0) begin
      case (a[9:2])
        CTRL_IDX:  s = SEL_CTRL;
        MODE_IDX:  s = SEL_MODE;
        TL0_IDX:   s = SEL_TL0;
        TL1_IDX:   s = SEL_TL1;
        TH0_IDX:   s = SEL_TH0;
        TH1_IDX:   s = SEL_TH1;
        BSET_IDX:  s = SEL_BSET;
        BCLR_IDX:  s = SEL_BCLR;
        ISTAT_IDX: s = SEL_ISTAT;
        IMASK_IDX: s = SEL_IMASK;
        default:   s = SEL_NONE;
      endcase
    end
    return s;
  endfunction : decodeSel

  // One counting step: {overflow, high, low}
  // Mode 00 keeps low bits 7:5
  // Mode 01 counts all sixteen bits
  // Mode 10 reloads low from high
  // Split: low byte only
  function automatic logic [16:0] stepCnt(input logic [1:0] m, input logic [7:0] hi,
                                          input logic [7:0] lo, input logic inc);
    logic [5:0]  p;
    logic [8:0]  h;
    logic [8:0]  l;
    logic [16:0] r;
    p = {1'b0, lo[4:0]} + 6'h01;
    h = {1'b0, hi} + {8'h00, p[5]};
    l = {1'b0, lo} + 9'h001;
    r = {1'b0, hi, lo};
    if (inc) begin
      case (m)
        MODE_PRESCALE: r = {h[8], h[7:0], lo[7:5], p[4:0]};
        MODE_FULL:     r = {1'b0, hi, lo} + 17'h00001;
        MODE_RELOAD:   r = {l[8], hi, (l[8] ? hi : l[7:0])};
        default:       r = {l[8], hi, l[7:0]};
      endcase
    end
    return r;
  endfunction : stepCnt

  logic [7:0]        ctrl_q, mode_q, tl0_q, tl1_q, th0_q, th1_q;
  logic [3:0]        istat_q, imask_q;
  logic [3:0]        syncA_q, syncB_q, syncC_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic [7:0]        wData_q;
  logic              wLane_q, awHave_q, wHave_q;
  logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q, irq_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [31:0]       rdata_q;

  // Pin synchronisers; third stage only for edge detection
  // Reset to idle ones: no false fall
  // Levels read the second stage
  wire  [3:0] pinsRaw  = {extintOnePin, extintZeroPin, countInOnePin, countInZeroPin};
  wire  [3:0] pinFall  = syncC_q & ~syncB_q;
  wire        cnt0Fall = pinFall[0];
  wire        cnt1Fall = pinFall[1];
  wire        x0Fall   = pinFall[2];
  wire        x1Fall   = pinFall[3];
  wire        x0High   = syncB_q[2];
  wire        x1High   = syncB_q[3];

  // Timer enables
  // Gate and run are levels
  // Pin counts come from the edges
  // Timer one held in mode 11
  wire [1:0]  mode0  = mode_q[T0_MODE_HI:T0_MODE_LO];
  wire [1:0]  mode1  = mode_q[T1_MODE_HI:T1_MODE_LO];
  wire        run0   = ctrl_q[T0_RUN_BIT] & (~mode_q[T0_GATE_BIT] | x0High);
  wire        run1   = ctrl_q[T1_RUN_BIT] & (~mode_q[T1_GATE_BIT] | x1High);
  wire        inc0   = run0 & (mode_q[T0_SRC_BIT] ? cnt0Fall : 1'b1);
  wire        inc1   = run1 & (mode_q[T1_SRC_BIT] ? cnt1Fall : 1'b1)
                       & (mode1 != MODE_SPLIT);
  wire        split0 = (mode0 == MODE_SPLIT);
  // Split high byte is a timer only, run by timer one's run bit
  // Ignores timer one's gate and source
  wire        incTh0 = split0 & ctrl_q[T1_RUN_BIT];

  wire [16:0] step0  = stepCnt(mode0, th0_q, tl0_q, inc0);
  wire [16:0] step1  = stepCnt(mode1, th1_q, tl1_q, inc1);
  wire [8:0]  th0Sum = {1'b0, th0_q} + {8'h00, incTh0};
  wire        ovf0   = step0[16];
  // Timer one flag taken over by split high byte while timer zero splits
  wire        ovf1   = split0 ? th0Sum[8] : step1[16];

  // Bus handshake terms
  // A write applies with both halves held
  // and no response pending
  // Read select decodes the live address
  wire        awFire = s_axi_awvalid & awready_q;
  wire        wFire  = s_axi_wvalid & wready_q;
  wire        arFire = s_axi_arvalid & arready_q;
  wire        doWr   = awHave_q & wHave_q & ~bvalid_q;
  wire [3:0]  wSel   = decodeSel(awAddr_q);
  wire [3:0]  rSel   = decodeSel(s_axi_araddr);
  wire        wrOk   = doWr & wLane_q;
  wire        wrCtrl = wrOk & (wSel == SEL_CTRL);
  wire        wrMode = wrOk & (wSel == SEL_MODE);
  wire        wrTl0  = wrOk & (wSel == SEL_TL0);
  wire        wrTl1  = wrOk & (wSel == SEL_TL1);
  wire        wrTh0  = wrOk & (wSel == SEL_TH0);
  wire        wrTh1  = wrOk & (wSel == SEL_TH1);
  wire        wrSet  = wrOk & (wSel == SEL_BSET);
  wire        wrClr  = wrOk & (wSel == SEL_BCLR);
  wire        wrStat = wrOk & (wSel == SEL_ISTAT);
  wire        wrMask = wrOk & (wSel == SEL_IMASK);

  // Software view of control: byte write, or bit set / bit clear
  // Set and clear words avoid a
  // read-modify-write race
  wire [7:0]  ctrlSw = wrCtrl ? wData_q :
                       wrSet  ? (ctrl_q | wData_q) :
                       wrClr  ? (ctrl_q & ~wData_q) : ctrl_q;

  // Request triggers by type bit
  // Level type triggers while low
  wire        x0Trig = ctrl_q[X0_TYPE_BIT] ? x0Fall : ~x0High;
  wire        x1Trig = ctrl_q[X1_TYPE_BIT] ? x1Fall : ~x1High;

  // Hardware set beats service clear and software clear in the same cycle
  // An event is never lost to a clear
  // Level requests follow the pin;
  // writes to them do not last
  wire        tf1D   = ovf1 | (ctrlSw[T1_OVF_BIT] & ~ackTimerOne);
  wire        tf0D   = ovf0 | (ctrlSw[T0_OVF_BIT] & ~ackTimerZero);
  wire        ie1D   = ctrl_q[X1_TYPE_BIT] ?
                       (x1Fall | (ctrlSw[X1_REQ_BIT] & ~ackExtintOne)) : ~x1High;
  wire        ie0D   = ctrl_q[X0_TYPE_BIT] ?
                       (x0Fall | (ctrlSw[X0_REQ_BIT] & ~ackExtintZero)) : ~x0High;
  wire [7:0]  ctrl_d = {tf1D, ctrlSw[T1_RUN_BIT], tf0D, ctrlSw[T0_RUN_BIT],
                        ie1D, ctrlSw[X1_TYPE_BIT], ie0D, ctrlSw[X0_TYPE_BIT]};

  // Counter bytes; a software write wins over a count in the same cycle
  // That count is lost
  wire [7:0]  tl0_d  = wrTl0 ? wData_q : step0[7:0];
  wire [7:0]  th0_d  = wrTh0 ? wData_q : (split0 ? th0Sum[7:0] : step0[15:8]);
  wire [7:0]  tl1_d  = wrTl1 ? wData_q : step1[7:0];
  wire [7:0]  th1_d  = wrTh1 ? wData_q : step1[15:8];

  // Sticky events; a new event wins over a write-one clear
  // Bits: t0 ovf, t1 ovf, req0, req1
  // Registered irq is glitch free
  wire [3:0]  evt     = {x1Trig, x0Trig, ovf1, ovf0};
  wire [3:0]  istat_d = evt | (istat_q & ~(wrStat ? wData_q[3:0] : 4'h0));
  wire        irq_d   = |(istat_d & imask_q);

  // Read data selection
  // Set and clear words read control
  // Unmapped reads give zero
  wire [7:0]  rByte = (rSel == SEL_CTRL || rSel == SEL_BSET || rSel == SEL_BCLR) ? ctrl_q :
                      (rSel == SEL_MODE)  ? mode_q :
                      (rSel == SEL_TL0)   ? tl0_q :
                      (rSel == SEL_TL1)   ? tl1_q :
                      (rSel == SEL_TH0)   ? th0_q :
                      (rSel == SEL_TH1)   ? th1_q :
                      (rSel == SEL_ISTAT) ? {4'h0, istat_q} :
                      (rSel == SEL_IMASK) ? {4'h0, imask_q} : 8'h00;

  // Synchroniser chain
  // Two stages settle, third finds edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncA_q <= 4'hf;
      syncB_q <= 4'hf;
      syncC_q <= 4'hf;
    end else begin
      syncA_q <= pinsRaw;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
    end
  end

  // Timer and interrupt registers
  // Counters reset to zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q  <= CTRL_RST;
      mode_q  <= MODE_RST;
      tl0_q   <= CNT_RST;
      th0_q   <= CNT_RST;
      tl1_q   <= CNT_RST;
      th1_q   <= CNT_RST;
      istat_q <= IRQ_RST;
      imask_q <= IRQ_RST;
      irq_q   <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      mode_q  <= wrMode ? wData_q : mode_q;
      tl0_q   <= tl0_d;
      th0_q   <= th0_d;
      tl1_q   <= tl1_d;
      th1_q   <= th1_d;
      istat_q <= istat_d;
      imask_q <= wrMask ? wData_q[3:0] : imask_q;
      irq_q   <= irq_d;
    end
  end

  // Write channel: address and data taken in either order
  // Halves held until the write applies
  // Response stands until bready
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awAddr_q  <= '0;
      wData_q   <= 8'h00;
      wLane_q   <= 1'b0;
      awHave_q  <= 1'b0;
      wHave_q   <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (awFire) begin
        awAddr_q <= s_axi_awaddr;
      end
      if (wFire) begin
        wData_q <= s_axi_wdata[7:0];
        wLane_q <= s_axi_wstrb[0];
      end
      awHave_q  <= (awHave_q | awFire) & ~doWr;
      wHave_q   <= (wHave_q | wFire) & ~doWr;
      // Ready drops once an item is held, so one write at a time
      // Readies return after the response
      awready_q <= ~(awHave_q | awFire) & ~bvalid_q & ~doWr;
      wready_q  <= ~(wHave_q | wFire) & ~bvalid_q & ~doWr;
      if (doWr) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (wSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel: one read under way, answer one cycle after acceptance
  // Data captured at acceptance
  // stand until rready
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= RESP_OKAY;
    end else begin
      if (arFire) begin
        rvalid_q <= 1'b1;
        rdata_q  <= {24'h000000, rByte};
        rresp_q  <= (rSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
      arready_q <= ~arFire & ~(rvalid_q & ~s_axi_rready);
    end
  end

  // Outputs straight from flip-flops
  // Flags are control bits: one copy
  // for software and controller
  assign s_axi_awready         = awready_q;
  assign s_axi_wready          = wready_q;
  assign s_axi_bvalid          = bvalid_q;
  assign s_axi_bresp           = bresp_q;
  assign s_axi_arready         = arready_q;
  assign s_axi_rvalid          = rvalid_q;
  assign s_axi_rdata           = rdata_q;
  assign s_axi_rresp           = rresp_q;
  assign timerZeroOverflowFlag = ctrl_q[T0_OVF_BIT];
  assign timerOneOverflowFlag  = ctrl_q[T1_OVF_BIT];
  assign extintZeroRequestFlag = ctrl_q[X0_REQ_BIT];
  assign extintOneRequestFlag  = ctrl_q[X1_REQ_BIT];
  assign irq                   = irq_q;

endmodule : dtc_top

//--- dtc_chk_props.sv
// Checker for bus handshakes and flag behaviour of the timer block
module dtc_chk_props (
  input wire logic        clk,                   // Clock
  input wire logic        rstn,                  // Reset, low
  input wire logic        s_axi_awvalid,         // Aw offered
  input wire logic        s_axi_awready,         // Aw ready
  input wire logic        s_axi_bvalid,          // Resp valid
  input wire logic        s_axi_bready,          // Resp ready
  input wire logic        s_axi_arvalid,         // Ar offered
  input wire logic        s_axi_arready,         // Ar ready
  input wire logic        s_axi_rvalid,          // Read valid
  input wire logic        s_axi_rready,          // Read ready
  input wire logic [31:0] s_axi_rdata,           // Read data
  input wire logic        extintZeroPin,         // Pin zero
  input wire logic        extintOnePin,          // Pin one
  input wire logic        extintZeroRequestFlag, // Request zero
  input wire logic        extintOneRequestFlag,  // Request one
  input wire logic        timerZeroOverflowFlag, // Overflow zero
  input wire logic        ackTimerZero           // Service zero
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Handshakes: one transfer at a time, answers at the stated distance
  chk_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address taken twice");
  chk_ar_refused: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
    else $error("read address taken twice");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[2:3] s_axi_bvalid)
    else $error("write response late");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");

  // Request flags see a pin fall through the synchroniser; service clears overflow
  chk_ext0_seen: assert property ($fell(extintZeroPin) |-> ##[1:5] extintZeroRequestFlag)
    else $error("request zero missed");
  chk_ext1_seen: assert property ($fell(extintOnePin) |-> ##[1:5] extintOneRequestFlag)
    else $error("request one missed");
  chk_t0_ack_clear: assert property (ackTimerZero && timerZeroOverflowFlag |=> !timerZeroOverflowFlag)
    else $error("overflow zero not cleared by service");

  cov_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_t0_ovf: cover property ($rose(timerZeroOverflowFlag));
  cov_x1: cover property ($rose(extintOneRequestFlag));
endmodule : dtc_chk_props

bind dtc_top dtc_chk_props u_props (.clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .extintZeroPin, .extintOnePin, .extintZeroRequestFlag, .extintOneRequestFlag,
  .timerZeroOverflowFlag, .ackTimerZero);

//--- dtc_irq_model.sv
// Interrupt controller model: acknowledges raised flags after a delay
module dtc_irq_model (
  input  wire logic       clk,      // Clock
  input  wire logic       rstn,     // Reset, low
  input  wire logic       ackEn,    // Service enabled
  input  wire logic [3:0] ackDelay, // Cycles before service
  input  wire logic [3:0] flags,    // Raised flags
  output logic      [3:0] acks      // One-cycle service pulses
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] ackCnt_q;

  // Lowest flag first; waits out the previous pulse so one flag is served at a time
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ackCnt_q <= 4'h0;
      acks     <= 4'h0;
    end else begin
      acks <= 4'h0;
      if (ackEn && |flags && !(|acks)) begin
        ackCnt_q <= ackCnt_q + 4'h1;
        if (ackCnt_q >= ackDelay) begin
          acks     <= flags & (~flags + 4'h1);
          ackCnt_q <= 4'h0;
        end
      end
    end
  end
endmodule : dtc_irq_model

//--- dual_timer_counter_extint_tb.sv
// Self-checking bench for the dual timer/counter block
module dual_timer_counter_extint_tb import dtc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk = 1'b0, rstn = 1'b0, ackEn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'hf, ackDelay = 4'h0;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, resp;
  logic              countInZeroPin = 1'b1, countInOnePin = 1'b1;
  logic              extintZeroPin = 1'b1, extintOnePin = 1'b1, irq;
  logic              ackTimerZero, ackTimerOne, ackExtintZero, ackExtintOne;
  logic              timerZeroOverflowFlag, timerOneOverflowFlag;
  logic              extintZeroRequestFlag, extintOneRequestFlag;
  logic [7:0]        tmode [3] = '{8'h50, 8'hd0, 8'h70};
  int                fails = 0, checked = 0, cyc = 0, seed = 32'hc7b7ecc9;
  int                k, m, n, tl, th, e;

  dtc_top dut (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .countInZeroPin, .countInOnePin, .extintZeroPin, .extintOnePin,
    .ackTimerZero, .ackTimerOne, .ackExtintZero, .ackExtintOne, .timerZeroOverflowFlag,
    .timerOneOverflowFlag, .extintZeroRequestFlag, .extintOneRequestFlag, .irq);
  dtc_irq_model ctl (.clk, .rstn, .ackEn, .ackDelay,
    .flags({extintOneRequestFlag, extintZeroRequestFlag, timerOneOverflowFlag,
      timerZeroOverflowFlag}),
    .acks({ackExtintOne, ackExtintZero, ackTimerOne, ackTimerZero}));

  // Clock and hang guard; the sequence needs about a thousand cycles
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    @(posedge clk);
    s_axi_awaddr  <= {2'b00, idx, 2'b00};
    s_axi_wdata   <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [31:0] v);
    @(posedge clk);
    s_axi_araddr  <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rchk(input string nm, input logic [7:0] idx, input logic [31:0] ex);
    logic [31:0] v;
    rd(idx, v);
    chk(nm, ex, v);
  endtask : rchk

  // Gate open for exactly cnt cycles, then the synchroniser drains
  task automatic gate0(input int cnt);
    extintZeroPin <= 1'b1;
    repeat (cnt) @(posedge clk);
    extintZeroPin <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : gate0

  task automatic falls1(input int cnt);
    repeat (cnt) begin
      repeat (2) @(posedge clk);
      countInOnePin <= 1'b0;
      repeat (2) @(posedge clk);
      countInOnePin <= 1'b1;
    end
    repeat (6) @(posedge clk);
  endtask : falls1

  task automatic settle();
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // Slow or prompt service by the controller model
  task automatic service();
    @(posedge clk);
    ackDelay <= 4'($random(seed));
    ackEn    <= 1'b1;
    repeat (60) @(posedge clk);
    ackEn    <= 1'b0;
    @(negedge clk);
  endtask : service

  // Reference timer: cnt steps from h:l in mode md; bit 16 marks overflow
  function automatic int step(int md, int cnt, int h, int l);
    int o = 0;
    repeat (cnt) begin
      l = (md == 0) ? ((l & 8'he0) | ((l + 1) & 8'h1f)) : ((l + 1) & 8'hff);
      if ((md == 0 ? l & 8'h1f : l) == 0) begin
        if (md < 2) h = (h + 1) & 8'hff;
        o = o | (md > 1 || h == 0);
        if (md == 2) l = h;
      end
    end
    return (o << 16) | (h << 8) | l;
  endfunction : step

  task automatic finish_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (k = 0; k < 6; k++) rchk("reset value", 8'(CTRL_IDX + k), 0);
    wr(8'h80, 8'h5a);
    chk("write resp", RESP_SLVERR, resp);
    rchk("unmapped", 8'h80, 0);
    chk("read resp", RESP_SLVERR, resp);
    $display("registers done");
    wr(CTRL_IDX, 8'h01);
    extintZeroPin <= 1'b0;
    for (k = 0; k < 8; k++) begin
      m  = k % 4;
      tl = $random(seed) & 8'hff;
      th = (k < 4) ? 8'hff : $random(seed) & 8'hff;
      n  = 1 + ($random(seed) & 8'h3f);
      wr(MODE_IDX, 8'(8 + m));
      wr(TL0_IDX, 8'(tl));
      wr(TH0_IDX, 8'(th));
      wr(CTRL_IDX, 8'h11);
      gate0(n);
      e = step(m, n, th, tl);
      rchk("timer0 low", TL0_IDX, e & 8'hff);
      rchk("timer0 high", TH0_IDX, (e >> 8) & 8'hff);
      rchk("control", CTRL_IDX, 8'h13 | ((e >> 11) & 8'h20));
    end
    $display("timer zero modes done");
    wr(IMASK_IDX, 8'h00);
    wr(ISTAT_IDX, 8'h0f);
    wr(MODE_IDX, 8'h09);
    wr(TL0_IDX, 8'hfe);
    wr(TH0_IDX, 8'hff);
    wr(CTRL_IDX, 8'h11);
    gate0(4);
    settle();
    chk("irq masked", 0, irq);
    chk("t0 flag", 1, timerZeroOverflowFlag);
    rchk("status", ISTAT_IDX, 8'h05);
    wr(IMASK_IDX, 8'h01);
    settle();
    chk("irq raised", 1, irq);
    wr(ISTAT_IDX, 8'h01);
    settle();
    chk("irq cleared", 0, irq);
    service();
    chk("t0 flag", 0, timerZeroOverflowFlag);
    chk("x0 flag", 0, extintZeroRequestFlag);
    $display("interrupt done");
    wr(MODE_IDX, tmode[0]);
    wr(CTRL_IDX, 8'h40);
    extintOnePin <= 1'b0;
    for (k = 0; k < 3; k++) begin
      wr(MODE_IDX, tmode[k]);
      falls1(4);
      rchk("timer1 low", TL1_IDX, 4);
    end
    for (k = 0; k < 2; k++) begin
      wr(CTRL_IDX, 8'(k << 2));
      extintOnePin <= 1'b0;
      settle();
      chk("x1 low", 1, extintOneRequestFlag);
      @(posedge clk);
      extintOnePin <= 1'b1;
      settle();
      chk("x1 high", k, extintOneRequestFlag);
    end
    $display("timer one and request one done");
    wr(MODE_IDX, 8'h03);
    extintZeroPin <= 1'b1;
    wr(TH0_IDX, 8'hf0);
    wr(BSET_IDX, 8'h40);
    repeat (40) @(posedge clk);
    wr(BCLR_IDX, 8'h40);
    rchk("control", CTRL_IDX, 8'h8c);
    service();
    chk("t1 flag", 0, timerOneOverflowFlag);
    chk("x1 flag", 0, extintOneRequestFlag);
    $display("split mode done");
    finish_test();
  end
endmodule : dual_timer_counter_extint_tb
